// ==== core/sts_pkg.sv ====
// Purpose: Constants, types and helpers for the self-test supervisor.
// Assumes: 20 MHz core clock; measurements arrive as unsigned millivolts.
// Notes: Flag vectors hold one bit per self-test, indexed by FLG_*.
package sts_pkg;

    // Clock rate
    localparam longint unsigned CLK_HZ = 64'h131_2d00;

    // Self-test flag positions
    localparam int NFLG = 8;
    localparam int NCH = 8;
    localparam int FLG_CHAN = 0;
    localparam int FLG_GND_OFS = 1;
    localparam int FLG_S5 = 2;
    localparam int FLG_S15 = 3;
    localparam int FLG_RAM = 4;
    localparam int FLG_ROM = 5;
    localparam int FLG_SET = 6;
    localparam int FLG_ADC = 7;

    // Action masks per flag position
    localparam logic [7:0] PROT_MASK = 8'hfc;
    localparam logic [7:0] CTRL_MASK = 8'h74;
    localparam logic [7:0] PERM_MASK = 8'hfc;
    localparam logic [7:0] PULSE_MASK = 8'h03;

    // Offset limits in mV
    localparam logic [15:0] OFS_WARN_MV = 16'h0032;
    localparam logic [15:0] OFS_FAIL_MV = 16'h004b;

    // Supply nominals and deviation limits in mV
    localparam logic [15:0] S5_NOM_MV = 16'h1388;
    localparam logic [15:0] S5_WARN_MV = 16'h012c;
    localparam logic [15:0] S5_FAIL_MV = 16'h0190;
    localparam logic [15:0] S15_NOM_MV = 16'h3a98;
    localparam logic [15:0] S15_WARN_MV = 16'h0320;
    localparam logic [15:0] S15_FAIL_MV = 16'h04b0;

    // Timing
    localparam longint unsigned ALARM_PULSE_MS = 64'h3e8;
    localparam longint unsigned ALARM_PULSE_CYC = CLK_HZ / 64'h3e8 * ALARM_PULSE_MS;
    localparam longint unsigned PERIOD_S = 64'h78;
    localparam longint unsigned PERIOD_CYC = CLK_HZ * PERIOD_S;
    localparam longint unsigned ADC_TIMEOUT_US = 64'h32;
    localparam longint unsigned ADC_TIMEOUT_CYC = CLK_HZ / 64'hf_4240 * ADC_TIMEOUT_US;
    localparam logic [9:0] ADC_TIMEOUT_CNT = 10'(ADC_TIMEOUT_CYC - 64'h1);

    // Reset values
    localparam logic [7:0] FLAGS_RST = 8'h00;
    localparam logic [15:0] ADDR_RST = 16'h0000;

    // Sequencer states
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_ADC = 2'b01,
        ST_EVAL = 2'b10
    } sts_state_t;

    // Absolute deviation of a reading from nominal
    function automatic logic [15:0] sts_dev(input logic [15:0] meas, input logic [15:0] nom);
        sts_dev = (meas > nom) ? meas - nom : nom - meas;
    endfunction : sts_dev

    // Grade a value: bit1 failure, bit0 warning
    function automatic logic [1:0] sts_grade(input logic [15:0] val, input logic [15:0] warn,
                                             input logic [15:0] fail);
        sts_grade = {val > fail, val > warn};
    endfunction : sts_grade

endpackage : sts_pkg

// ==== core/sts_supervisor.sv ====
// Purpose: Self-test supervisor: runs checks, grades results, drives alarm and disables.
// Assumes: Measurement inputs come from logic on core_clk and are stable during a run.
// Notes: Failures latch until reset; warnings follow the latest run.
`timescale 1ns/1ps

// Functional notes
// - Request a status message whenever any self-test result changes.
// - Close the alarm contact when any self-test fails.
// - Certain failures disable control, set driver port to input, block outputs.
// - Run all tests at power-up and before new settings become active.
// - Repeat the tests periodically, at most a few minutes apart.
// - Channel offset warns above 50 mV and fails above 75 mV.
// - The 5 V supply warns beyond 0.3 V and fails beyond 0.4 V.
// - The 15 V rails warn beyond 0.8 V, fail beyond 1.2 V; protection only.
// - 5 V failure blocks outputs, disables protection and control, holds alarm.
// - RAM test has no warning; failure reports address, disables all, holds alarm.
// - ROM checksum mismatch fails, disables protection and control, holds alarm.
// - Slow or missing conversion fails; protection off, control kept, alarm.
// - Grounded converter input offset warns above 50 mV, fails above 75 mV.
// - Offset failure pulses the alarm for one second without disabling anything.
// - Differing setting images fail, disable protection and control, hold alarm.
// - Warnings neither close the alarm nor disable any function.
module sts_supervisor
    import sts_pkg::*;
#(
    parameter logic [31:0] PERIOD_CYCLES = 32'(PERIOD_CYC),
    parameter logic [31:0] ALARM_PULSE_CYCLES = 32'(ALARM_PULSE_CYC)
) (
    input wire logic core_clk,
    input wire logic reset,
    input wire logic settings_apply_req,
    input wire logic [7:0] chan_offset_mv [NCH],
    input wire logic [7:0] master_offset_mv,
    input wire logic [15:0] supply_5v_mv,
    input wire logic [15:0] supply_pos15_mv,
    input wire logic [15:0] supply_neg15_mv,
    input wire logic ram_error,
    input wire logic [15:0] ram_error_addr,
    input wire logic [15:0] rom_sum_calc,
    input wire logic [15:0] rom_sum_stored,
    input wire logic [31:0] setting_image_a,
    input wire logic [31:0] setting_image_b,
    input wire logic adc_done,
    output logic adc_start,
    output logic test_busy,
    output logic settings_enable,
    output logic status_req,
    output logic alarm_contact,
    output logic protect_disable,
    output logic control_disable,
    output logic driver_input_mode,
    output logic outputs_blocked,
    output logic [7:0] warn_flags,
    output logic [7:0] fail_flags,
    output logic [15:0] ram_fault_addr
);

    sts_state_t state;
    sts_state_t next_state;
    logic run_pending;
    logic apply_pending;
    logic adc_bad;
    logic [9:0] adc_cnt;
    logic [31:0] period_cnt;
    logic [31:0] pulse_cnt;
    logic [1:0] g_chan;
    logic [1:0] g_gnd;
    logic [1:0] g_s5;
    logic [1:0] g_s15;
    logic [1:0] g_s15p;
    logic [1:0] g_s15n;
    logic [7:0] run_warn;
    logic [7:0] run_fail;
    logic [7:0] next_warn;
    logic [7:0] next_fail;
    logic evaluating;
    logic period_hit;
    logic flags_change;
    logic pulse_fire;

    // worst grade over all analog channels
    always_comb begin
        g_chan = 2'b00;
        for (int i = 0; i < NCH; i++) begin
            g_chan = g_chan | sts_grade({8'h00, chan_offset_mv[i]}, OFS_WARN_MV, OFS_FAIL_MV);
        end
    end

    assign g_gnd = sts_grade({8'h00, master_offset_mv}, OFS_WARN_MV, OFS_FAIL_MV);
    assign g_s5 = sts_grade(sts_dev(supply_5v_mv, S5_NOM_MV), S5_WARN_MV, S5_FAIL_MV);
    // both 15 V rails, negative one as magnitude
    assign g_s15p = sts_grade(sts_dev(supply_pos15_mv, S15_NOM_MV), S15_WARN_MV, S15_FAIL_MV);
    assign g_s15n = sts_grade(sts_dev(supply_neg15_mv, S15_NOM_MV), S15_WARN_MV, S15_FAIL_MV);
    assign g_s15 = g_s15p | g_s15n;

    assign run_warn = {4'h0, g_s15[0], g_s5[0], g_gnd[0], g_chan[0]};
    assign run_fail = {adc_bad, setting_image_a != setting_image_b,
                       rom_sum_calc != rom_sum_stored, ram_error,
                       g_s15[1], g_s5[1], g_gnd[1], g_chan[1]};

    // failures accumulate; warnings track latest run
    assign evaluating = (state == ST_EVAL);
    assign next_fail = fail_flags | (evaluating ? run_fail : FLAGS_RST);
    assign next_warn = evaluating ? (run_warn & ~run_fail) : warn_flags;
    assign flags_change = evaluating && ({next_warn, next_fail} != {warn_flags, fail_flags});
    // each detected offset failure retriggers the pulse
    assign pulse_fire = evaluating && ((run_fail & PULSE_MASK) != FLAGS_RST);
    assign period_hit = (period_cnt == 32'h0000_0000);

    // Sequencer transitions
    always_comb begin
        next_state = state;
        case (state)
            ST_IDLE: begin
                if (run_pending) begin
                    next_state = ST_ADC;
                end
            end
            ST_ADC: begin
                if (adc_done || adc_cnt == 10'h000) begin
                    next_state = ST_EVAL;
                end
            end
            ST_EVAL: begin
                next_state = ST_IDLE;
            end
            default: begin
                next_state = ST_IDLE;
            end
        endcase
    end

    // State register and run requests
    always_ff @(posedge core_clk) begin
        if (reset) begin
            state <= ST_IDLE;
            run_pending <= 1'b1;
            apply_pending <= 1'b0;
        end else begin
            state <= next_state;
            // new settings and period both request a run
            run_pending <= (run_pending && state != ST_IDLE) || settings_apply_req || period_hit;
            apply_pending <= settings_apply_req || (apply_pending && !evaluating);
        end
    end

    // conversion timer, timeout counts as failure
    always_ff @(posedge core_clk) begin
        if (reset) begin
            adc_cnt <= ADC_TIMEOUT_CNT;
            adc_bad <= 1'b0;
        end else if (state == ST_IDLE) begin
            adc_cnt <= ADC_TIMEOUT_CNT;
        end else if (state == ST_ADC) begin
            adc_cnt <= adc_cnt - 10'h001;
            adc_bad <= !adc_done && (adc_cnt == 10'h000);
        end
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            period_cnt <= PERIOD_CYCLES - 32'h0000_0001;
            pulse_cnt <= 32'h0000_0000;
        end else begin
            period_cnt <= period_hit ? PERIOD_CYCLES - 32'h0000_0001 : period_cnt - 32'h0000_0001;
            if (pulse_fire) begin
                pulse_cnt <= ALARM_PULSE_CYCLES;
            end else if (pulse_cnt != 32'h0000_0000) begin
                pulse_cnt <= pulse_cnt - 32'h0000_0001;
            end
        end
    end

    // Flags, RAM address and sequencing strobes
    always_ff @(posedge core_clk) begin
        if (reset) begin
            warn_flags <= FLAGS_RST;
            fail_flags <= FLAGS_RST;
            ram_fault_addr <= ADDR_RST;
            status_req <= 1'b0;
            adc_start <= 1'b0;
            settings_enable <= 1'b0;
            test_busy <= 1'b0;
        end else begin
            warn_flags <= next_warn;
            fail_flags <= next_fail;
            if (evaluating && ram_error && !fail_flags[FLG_RAM]) begin
                ram_fault_addr <= ram_error_addr;
            end
            status_req <= flags_change;
            adc_start <= (state == ST_IDLE) && run_pending;
            settings_enable <= evaluating && apply_pending;
            test_busy <= (next_state != ST_IDLE);
        end
    end

    // action outputs from latched failures and the offset alarm pulse timer
    always_ff @(posedge core_clk) begin
        if (reset) begin
            alarm_contact <= 1'b0;
            protect_disable <= 1'b0;
            control_disable <= 1'b0;
            driver_input_mode <= 1'b0;
            outputs_blocked <= 1'b0;
        end else begin
            alarm_contact <= ((fail_flags & PERM_MASK) != FLAGS_RST)
                             || (pulse_cnt != 32'h0000_0000);
            protect_disable <= (fail_flags & PROT_MASK) != FLAGS_RST;
            // control off, driver port input, outputs blocked
            control_disable <= (fail_flags & CTRL_MASK) != FLAGS_RST;
            driver_input_mode <= (fail_flags & CTRL_MASK) != FLAGS_RST;
            outputs_blocked <= (fail_flags & CTRL_MASK) != FLAGS_RST;
        end
    end

    // Checks on the supervisor behaviour
    chk_status_change: assert property (@(posedge core_clk) disable iff (reset)
        flags_change |=> status_req)
        else $error("status request missing after flag change");

    chk_alarm_perm: assert property (@(posedge core_clk) disable iff (reset)
        ((fail_flags & PERM_MASK) != FLAGS_RST) |=> alarm_contact)
        else $error("alarm open while failure latched");

    chk_output_block: assert property (@(posedge core_clk) disable iff (reset)
        ((fail_flags & CTRL_MASK) != FLAGS_RST)
        |=> (control_disable && outputs_blocked && driver_input_mode))
        else $error("outputs not blocked while control disabled");

    chk_apply_run: assert property (@(posedge core_clk) disable iff (reset)
        (settings_apply_req && state == ST_IDLE && !run_pending) |-> ##2 adc_start)
        else $error("no run before settings apply");

    chk_period_run: assert property (@(posedge core_clk) disable iff (reset)
        (period_hit && state == ST_IDLE && !run_pending) |-> ##[1:2] adc_start)
        else $error("no periodic run");

    chk_chan_fail: assert property (@(posedge core_clk) disable iff (reset)
        (evaluating && g_chan[1]) |=> fail_flags[FLG_CHAN])
        else $error("channel offset failure not latched");

    chk_s15_scope: assert property (@(posedge core_clk) disable iff (reset)
        (fail_flags == 8'h08) |=> (protect_disable && !control_disable))
        else $error("15 V failure action wrong");

    chk_adc_timeout: assert property (@(posedge core_clk) disable iff (reset)
        (state == ST_ADC && adc_cnt == 10'h000 && !adc_done) |=> ##1 fail_flags[FLG_ADC])
        else $error("conversion timeout not flagged");

    chk_offset_pulse: assert property (@(posedge core_clk) disable iff (reset)
        pulse_fire |-> ##2 alarm_contact [*8])
        else $error("offset alarm pulse missing");

    chk_warn_quiet: assert property (@(posedge core_clk) disable iff (reset)
        (fail_flags == FLAGS_RST && $past(fail_flags) == FLAGS_RST)
        |=> (!protect_disable && !control_disable && !alarm_contact))
        else $error("warning disabled a function");

    chk_fail_sticky: assert property (@(posedge core_clk) disable iff (reset)
        ((fail_flags & $past(fail_flags)) == $past(fail_flags)))
        else $error("latched failure cleared");

    chk_s5_fail: assert property (@(posedge core_clk) disable iff (reset)
        (evaluating && g_s5[1]) |=> (fail_flags[FLG_S5] && !warn_flags[FLG_S5]))
        else $error("5 V failure not latched");

    chk_s5_block: assert property (@(posedge core_clk) disable iff (reset)
        fail_flags[FLG_S5] |=> (outputs_blocked && driver_input_mode && protect_disable
                                && control_disable && alarm_contact))
        else $error("5 V failure actions missing");

    chk_ram_addr: assert property (@(posedge core_clk) disable iff (reset)
        (evaluating && ram_error && !fail_flags[FLG_RAM])
        |=> (fail_flags[FLG_RAM] && ram_fault_addr == $past(ram_error_addr)))
        else $error("RAM failure address not captured");

    chk_rom_fail: assert property (@(posedge core_clk) disable iff (reset)
        (evaluating && rom_sum_calc != rom_sum_stored) |=> fail_flags[FLG_ROM])
        else $error("checksum mismatch not latched");

    chk_adc_scope: assert property (@(posedge core_clk) disable iff (reset)
        (fail_flags == 8'h80) |=> (protect_disable && !control_disable && alarm_contact))
        else $error("converter failure action wrong");

    chk_gnd_fail: assert property (@(posedge core_clk) disable iff (reset)
        (evaluating && g_gnd[1]) |=> (fail_flags[FLG_GND_OFS] && !warn_flags[FLG_GND_OFS]))
        else $error("grounded input offset failure not latched");

    chk_image_fail: assert property (@(posedge core_clk) disable iff (reset)
        (evaluating && setting_image_a != setting_image_b) |=> fail_flags[FLG_SET])
        else $error("setting image mismatch not latched");

    chk_settings_gate: assert property (@(posedge core_clk) disable iff (reset)
        settings_enable |-> $past(evaluating))
        else $error("settings enabled without a finished run");

endmodule : sts_supervisor

// ==== verif/sts_adc_model.sv ====
// Purpose: Converter model that answers conversion starts from the supervisor.
// Assumes: adc_start is a one-cycle pulse on core_clk.
// Notes: The bench sets the answer delay and a mode that never answers.
`timescale 1ns/1ps
module sts_adc_model (
    input wire logic core_clk,
    input wire logic adc_start,
    input wire logic [11:0] delay_cyc,
    input wire logic hang,
    output logic adc_done
);
    int cnt = -1;

    // Count down after a start, then pulse done once unless hung
    always @(posedge core_clk) begin
        adc_done <= 1'b0;
        if (adc_start === 1'b1) begin
            cnt <= int'(delay_cyc);
        end else if (cnt > 0) begin
            cnt <= cnt - 1;
        end else if (cnt == 0) begin
            cnt <= -1;
            adc_done <= !hang;
        end
    end
endmodule : sts_adc_model

// ==== verif/testbench.sv ====
// Purpose: Self-checking bench for the self-test supervisor.
// Assumes: Short period and pulse parameters; inputs change on falling edges.
// Notes: Each test except the final periodic run check resets, injects one condition, runs the tests, checks actions.
`timescale 1ns/1ps
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin bad_count++; $display("unexpected at %0t: got %h want %h", $time, a, b); end end
module testbench;
    import sts_pkg::*;
    localparam logic [7:0] EXP_PROT = 8'hfc;
    localparam logic [7:0] EXP_CTRL = 8'h74;
    logic core_clk = 1'b0;
    logic reset = 1'b1;
    logic settings_apply_req = 1'b0;
    logic [7:0] chan_offset_mv [NCH];
    logic [7:0] master_offset_mv;
    logic [15:0] supply_5v_mv, supply_pos15_mv, supply_neg15_mv;
    logic ram_error, hang;
    logic [15:0] ram_error_addr, rom_sum_calc, rom_sum_stored;
    logic [31:0] setting_image_a, setting_image_b;
    logic [11:0] adc_delay;
    logic adc_done, adc_start, test_busy, settings_enable, status_req, alarm_contact;
    logic protect_disable, control_disable, driver_input_mode, outputs_blocked;
    logic [7:0] warn_flags, fail_flags;
    logic [15:0] ram_fault_addr;
    int bad_count = 0;
    int total_checks = 0;
    int st_cnt = 0;

    // Clock and status request counter
    always #25 core_clk = ~core_clk;
    always @(posedge core_clk) begin
        if (status_req === 1'b1) st_cnt++;
    end

    sts_supervisor #(.PERIOD_CYCLES(32'h0000_0bb8), .ALARM_PULSE_CYCLES(32'h0000_0014))
    u_sts_supervisor (
        .core_clk(core_clk), .reset(reset), .settings_apply_req(settings_apply_req),
        .chan_offset_mv(chan_offset_mv), .master_offset_mv(master_offset_mv),
        .supply_5v_mv(supply_5v_mv), .supply_pos15_mv(supply_pos15_mv),
        .supply_neg15_mv(supply_neg15_mv), .ram_error(ram_error),
        .ram_error_addr(ram_error_addr), .rom_sum_calc(rom_sum_calc),
        .rom_sum_stored(rom_sum_stored), .setting_image_a(setting_image_a),
        .setting_image_b(setting_image_b), .adc_done(adc_done), .adc_start(adc_start),
        .test_busy(test_busy), .settings_enable(settings_enable), .status_req(status_req),
        .alarm_contact(alarm_contact), .protect_disable(protect_disable),
        .control_disable(control_disable), .driver_input_mode(driver_input_mode),
        .outputs_blocked(outputs_blocked), .warn_flags(warn_flags),
        .fail_flags(fail_flags), .ram_fault_addr(ram_fault_addr));

    sts_adc_model u_sts_adc_model (.core_clk(core_clk), .adc_start(adc_start),
        .delay_cyc(adc_delay), .hang(hang), .adc_done(adc_done));

    task automatic end_sim();
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : end_sim

    // A bounded wait that ran out ends the run
    task automatic wait_ok(input logic ok);
        total_checks++;
        if (ok !== 1'b1) begin
            bad_count++;
            $display("unexpected at %0t: wait ran out", $time);
            end_sim();
        end
    endtask : wait_ok

    // All readings healthy, converter answers quickly
    task automatic set_nom();
        foreach (chan_offset_mv[i]) chan_offset_mv[i] = 8'h0a;
        master_offset_mv = 8'h05;
        supply_5v_mv = 16'h1388;
        supply_pos15_mv = 16'h3a98;
        supply_neg15_mv = 16'h3a98;
        ram_error = 1'b0;
        ram_error_addr = 16'h0000;
        rom_sum_calc = 16'hbeef;
        rom_sum_stored = 16'hbeef;
        setting_image_a = 32'h5a5a5a5a;
        setting_image_b = 32'h5a5a5a5a;
        adc_delay = 12'h003;
        hang = 1'b0;
    endtask : set_nom

    // Level 1 warns, 2 fails, 3 sits exactly on the failure limit
    task automatic set_fault(input int k, input int l);
        case (k)
            0: chan_offset_mv[3] = l == 1 ? 8'h33 : (l == 2 ? 8'h4c : 8'h4b);
            1: master_offset_mv = l == 1 ? 8'h33 : (l == 2 ? 8'h4c : 8'h4b);
            2: supply_5v_mv = l == 1 ? 16'h125b : (l == 2 ? 16'h11f7 : 16'h1518);
            3: begin
                if (l == 2) supply_neg15_mv = 16'h35e7;
                else supply_pos15_mv = l == 1 ? 16'h3db9 : 16'h3f48;
            end
            4: begin
                ram_error = 1'b1;
                ram_error_addr = 16'h1234;
            end
            5: rom_sum_calc = 16'hbeee;
            6: setting_image_b = 32'h00000000;
            default: hang = 1'b1;
        endcase
    endtask : set_fault

    // Request a run and wait for the new settings to go live
    task automatic run_apply();
        int i;
        settings_apply_req = 1'b1;
        @(negedge core_clk);
        settings_apply_req = 1'b0;
        for (i = 0; i < 2500 && settings_enable !== 1'b1; i++) @(negedge core_clk);
        wait_ok(settings_enable);
        repeat (2) @(negedge core_clk);
    endtask : run_apply

    // Reset, then let the power-up run finish
    task automatic do_reset();
        int i;
        reset = 1'b1;
        repeat (10) @(negedge core_clk);
        `CHK({alarm_contact, fail_flags, protect_disable}, 10'h000)
        set_nom();
        reset = 1'b0;
        for (i = 0; i < 5 && test_busy !== 1'b1; i++) @(negedge core_clk);
        wait_ok(test_busy);
        for (i = 0; i < 1200 && test_busy !== 1'b0; i++) @(negedge core_clk);
        wait_ok(!test_busy);
        st_cnt = 0;
    endtask : do_reset

    initial begin
        set_nom();
        for (int k = 0; k < 4; k++) begin
            for (int l = 1; l < 4; l += 2) begin
                do_reset();
                set_fault(k, l);
                run_apply();
                `CHK(warn_flags, 8'h01 << k)
                `CHK(fail_flags, 8'h00)
                `CHK({alarm_contact, protect_disable, control_disable}, 3'b000)
                `CHK(st_cnt, 1)
                st_cnt = 0;
                set_nom();
                run_apply();
                `CHK(warn_flags, 8'h00)
                `CHK(st_cnt, 1)
                $display("warning test %0d level %0d done", k, l);
            end
        end
        for (int k = 0; k < 8; k++) begin
            do_reset();
            set_fault(k, 2);
            run_apply();
            `CHK(fail_flags, 8'h01 << k)
            `CHK(warn_flags, 8'h00)
            `CHK(protect_disable, EXP_PROT[k])
            `CHK(control_disable, EXP_CTRL[k])
            `CHK(driver_input_mode, EXP_CTRL[k])
            `CHK(outputs_blocked, EXP_CTRL[k])
            `CHK(alarm_contact, 1'b1)
            `CHK(st_cnt, 1)
            if (k == 4) `CHK(ram_fault_addr, 16'h1234)
            repeat (25) @(negedge core_clk);
            `CHK(alarm_contact, EXP_PROT[k])
            set_nom();
            run_apply();
            `CHK(fail_flags, 8'h01 << k)
            $display("failure test %0d done", k);
        end
        do_reset();
        adc_delay = 12'h384;
        run_apply();
        `CHK(fail_flags, 8'h00)
        adc_delay = 12'h003;
        $display("slow conversion test done");
        for (int i = 0; i < 3500 && adc_start !== 1'b1; i++) @(negedge core_clk);
        `CHK(adc_start, 1'b1)
        $display("periodic run test done");
        end_sim();
    end
endmodule : testbench
